//--- ftl_pkg.sv
// Constants, register indices and carrier types for the fan tach / LED bank.
// Assumes a 40 MHz pclk; all users refer to names as ftl_pkg::name.
`default_nettype none
package ftl_pkg;
   // ************************************************************
   // Timing
   // ************************************************************
   localparam int unsigned CLK_PERIOD_NS = 25;
   // Base tach count clock period, value is a plain default
   localparam int unsigned FAN_TICK_NS = 25000;
   localparam int unsigned FAN_TICK_CYCLES =
      (FAN_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned LED_HALF_MS = 500;
   localparam int unsigned NS_PER_MS = 1000000;
   localparam int unsigned LED_HALF_CYCLES =
      LED_HALF_MS * (NS_PER_MS / CLK_PERIOD_NS);

   // ************************************************************
   // Register indices (byte address is four times the index)
   // ************************************************************
   localparam logic [7:0] IDX_FAN_DIV = 8'h58;
   localparam logic [7:0] IDX_TACH_1 = 8'h59;
   localparam logic [7:0] IDX_TACH_2 = 8'h5A;
   localparam logic [7:0] IDX_PRE_1 = 8'h5B;
   localparam logic [7:0] IDX_PRE_2 = 8'h5C;
   localparam logic [7:0] IDX_LED_1 = 8'h5D;
   localparam logic [7:0] IDX_LED_2 = 8'h5E;
   localparam logic [7:0] IDX_SCAN = 8'h5F;
   localparam logic [7:0] IDX_RSV_LO = 8'h60;
   localparam logic [7:0] IDX_RSV_HI = 8'h7F;
   localparam int IDX_LSB = 2;
   localparam int IDX_MSB = 9;

   // ************************************************************
   // Fields and reset values
   // ************************************************************
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [1:0] DIV_RESET = 2'h1;
   localparam int DIV1_LSB = 4;
   localparam int DIV2_LSB = 6;
   localparam logic [7:0] CNT_MAX = 8'hFF;
   localparam logic [1:0] LED_OFF = 2'h0;
   localparam logic [1:0] LED_FAST = 2'h1;
   localparam logic [1:0] LED_SLOW = 2'h2;
   localparam logic [1:0] LED_ON = 2'h3;

   // ************************************************************
   // Carrier types
   // ************************************************************
   typedef struct packed {
      logic load;
      logic [1:0] div;
      logic [7:0] preload;
   } ftl_tach_ctrl_type;

   typedef enum logic [1:0] {
      FTL_IDLE,
      FTL_ACCESS
   } ftl_bus_state_type;
endpackage
`default_nettype wire

//--- ftl_tach.sv
// One fan tachometer channel: scaled tick counter and latched result.
// Assumes the fan pulse input is synchronous to pclk.
`timescale 1ns/100ps
`default_nettype none
module ftl_tach #(
   parameter int unsigned TICK_CYCLES = ftl_pkg::FAN_TICK_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire ftl_pkg::ftl_tach_ctrl_type ctrl,
   input wire logic fan_pulse,
   output logic [7:0] result
);
   localparam int TW = (TICK_CYCLES > 2) ? $clog2(TICK_CYCLES) : 1;
   localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

   if (TICK_CYCLES < 2) begin : g_tick_guard
      $error("TICK_CYCLES must be at least 2");
   end

   logic [TW-1:0] tick_cnt_q, tick_cnt_d;
   logic [2:0] pre_q, pre_d;
   logic [7:0] cnt_q, cnt_d;
   logic [7:0] result_q, result_d;
   logic pulse_q;
   logic tick, step, rise;
   logic [2:0] mask;

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb begin
      tick = (tick_cnt_q == TICK_LAST);
      tick_cnt_d = tick ? '0 : tick_cnt_q + 1'b1;
      mask = 3'((4'h1 << ctrl.div) - 4'h1);
      step = tick && ((pre_q & mask) == mask);
      pre_d = tick ? pre_q + 3'h1 : pre_q;
      rise = fan_pulse && !pulse_q;
      result_d = rise ? cnt_q : result_q;
      cnt_d = cnt_q;
      if (ctrl.load) begin
         cnt_d = ctrl.preload;
         pre_d = '0;
      end else if (rise) begin
         cnt_d = ctrl.preload;
      end else if (step && cnt_q != ftl_pkg::CNT_MAX) begin
         cnt_d = cnt_q + 8'h01;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_cnt_q <= '0;
         pre_q <= '0;
         cnt_q <= ftl_pkg::RST_ZERO;
         result_q <= ftl_pkg::RST_ZERO;
         pulse_q <= 1'b0;
      end else begin
         tick_cnt_q <= tick_cnt_d;
         pre_q <= pre_d;
         cnt_q <= cnt_d;
         result_q <= result_d;
         pulse_q <= fan_pulse;
      end
   end

   assign result = result_q;

   // ************************************************************
   // Checks
   // ************************************************************
   chk_result_latch: assert property (
      @(posedge pclk) disable iff (!presetn)
      rise |=> result_q == $past(cnt_q))
      else $error("result not latched from count on pulse edge");

   chk_preload_reset: assert property (
      @(posedge pclk) disable iff (!presetn)
      ctrl.load |=> cnt_q == $past(ctrl.preload))
      else $error("preload write did not reset the count");

   chk_count_sat: assert property (
      @(posedge pclk) disable iff (!presetn)
      (cnt_q == ftl_pkg::CNT_MAX && !rise && !ctrl.load)
      |=> cnt_q == ftl_pkg::CNT_MAX)
      else $error("count wrapped instead of saturating");

   chk_count_step: assert property (
      @(posedge pclk) disable iff (!presetn)
      (step && !rise && !ctrl.load && cnt_q != ftl_pkg::CNT_MAX)
      |=> cnt_q == $past(cnt_q) + 8'h01)
      else $error("count did not advance on a scaled tick");

   chk_div_spacing: assert property (
      @(posedge pclk) disable iff (!presetn)
      (step && ctrl.div == 2'h3) |=> (!step || ctrl.div != 2'h3) [*7])
      else $error("divide by eight stepped too soon");
endmodule
`default_nettype wire

//--- ftl_regs.sv
// Runtime register bank: two fan tach channels, two LEDs, scan-code hold.
// Assumes an APB master on pclk; fan pulses synchronous to pclk.
//
// How it works
// - Each fan channel reads an 8-bit tick count per fan pulse.
// - Result holds final count of previous pulse, latched at its end.
// - Each channel has an 8-bit read/write preload start value.
// - Writing a channel preload resets its running count at once.
// - LED field bits 1:0: 00 off, 11 on, 01 blinks 0.5 s on/off.
// - LED code 10 blinks 0.5 s lit, 1.5 s dark.
// - Scan-code register is 8-bit read/write, bit 0 least significant.
// - Reads of the reserved span above the scan code return zero.
// - Standby reset clears tach, preload, LED and scan-code registers.
// - Count clock divided by 1, 2, 4 or 8; reset divisor is 2.
//
// The APB slave port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module ftl_regs #(
   parameter int unsigned TICK_CYCLES = ftl_pkg::FAN_TICK_CYCLES,
   parameter int unsigned HALF_SEC_CYCLES = ftl_pkg::LED_HALF_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic fan_channel_one,
   input wire logic fan_channel_two,
   output logic indicator_one,
   output logic indicator_two
);
   localparam int HW = $clog2(HALF_SEC_CYCLES);
   localparam logic [HW-1:0] HALF_LAST = HW'(HALF_SEC_CYCLES - 1);

   if (HALF_SEC_CYCLES < 2) begin : g_half_guard
      $error("HALF_SEC_CYCLES must be at least 2");
   end

   // ************************************************************
   // Bus slave
   // ************************************************************
   ftl_pkg::ftl_bus_state_type st_q, st_d;
   logic [31:0] prdata_q, prdata_d;
   logic pready_q, pready_d;
   logic pslverr_q, pslverr_d;
   logic [7:0] idx;
   logic in_range, mapped, wr_fire, rd_fire;
   logic [7:0] tach1, tach2;
   logic [7:0] pre1_q, pre1_d, pre2_q, pre2_d, scan_q, scan_d;
   logic [1:0] mode1_q, mode1_d, mode2_q, mode2_d;
   logic [1:0] div1_q, div1_d, div2_q, div2_d;
   logic [7:0] rd_val;

   // Decode is registered in setup so prdata comes from a flop,
   // costing nothing: pready rises in the first access cycle.
   always_comb begin
      idx = paddr[ftl_pkg::IDX_MSB:ftl_pkg::IDX_LSB];
      in_range = (paddr[31:ftl_pkg::IDX_MSB+1] == '0) &&
                 (paddr[ftl_pkg::IDX_LSB-1:0] == '0);
      mapped = in_range && idx >= ftl_pkg::IDX_FAN_DIV &&
               idx <= ftl_pkg::IDX_RSV_HI;
      case (idx)
         ftl_pkg::IDX_FAN_DIV: begin
            rd_val = '0;
            rd_val[ftl_pkg::DIV1_LSB +: 2] = div1_q;
            rd_val[ftl_pkg::DIV2_LSB +: 2] = div2_q;
         end
         ftl_pkg::IDX_TACH_1: rd_val = tach1;
         ftl_pkg::IDX_TACH_2: rd_val = tach2;
         ftl_pkg::IDX_PRE_1: rd_val = pre1_q;
         ftl_pkg::IDX_PRE_2: rd_val = pre2_q;
         ftl_pkg::IDX_LED_1: rd_val = {6'h00, mode1_q};
         ftl_pkg::IDX_LED_2: rd_val = {6'h00, mode2_q};
         ftl_pkg::IDX_SCAN: rd_val = scan_q;
         default: rd_val = '0;
      endcase
      if (!mapped) begin
         rd_val = '0;
      end
      st_d = st_q;
      prdata_d = prdata_q;
      pready_d = 1'b0;
      pslverr_d = 1'b0;
      case (st_q)
         ftl_pkg::FTL_IDLE: begin
            if (psel && !penable) begin
               st_d = ftl_pkg::FTL_ACCESS;
               pready_d = 1'b1;
               pslverr_d = !mapped;
               prdata_d = pwrite ? '0 : {24'h000000, rd_val};
            end
         end
         ftl_pkg::FTL_ACCESS: begin
            st_d = ftl_pkg::FTL_IDLE;
            prdata_d = '0;
         end
         default: st_d = ftl_pkg::FTL_IDLE;
      endcase
      wr_fire = psel && penable && pready_q && pwrite && pstrb[0] &&
                mapped;
      rd_fire = psel && penable && pready_q && !pwrite;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= ftl_pkg::FTL_IDLE;
         prdata_q <= '0;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         st_q <= st_d;
         prdata_q <= prdata_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
      end
   end

   // ************************************************************
   // Software registers
   // ************************************************************
   always_comb begin
      pre1_d = pre1_q;
      pre2_d = pre2_q;
      mode1_d = mode1_q;
      mode2_d = mode2_q;
      scan_d = scan_q;
      div1_d = div1_q;
      div2_d = div2_q;
      if (wr_fire) begin
         case (idx)
            ftl_pkg::IDX_FAN_DIV: begin
               div1_d = pwdata[ftl_pkg::DIV1_LSB +: 2];
               div2_d = pwdata[ftl_pkg::DIV2_LSB +: 2];
            end
            ftl_pkg::IDX_PRE_1: pre1_d = pwdata[7:0];
            ftl_pkg::IDX_PRE_2: pre2_d = pwdata[7:0];
            // Reserved bits are dropped, they steer nothing
            ftl_pkg::IDX_LED_1: mode1_d = pwdata[1:0];
            ftl_pkg::IDX_LED_2: mode2_d = pwdata[1:0];
            ftl_pkg::IDX_SCAN: scan_d = pwdata[7:0];
            default: scan_d = scan_q;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre1_q <= ftl_pkg::RST_ZERO;
         pre2_q <= ftl_pkg::RST_ZERO;
         scan_q <= ftl_pkg::RST_ZERO;
         mode1_q <= ftl_pkg::LED_OFF;
         mode2_q <= ftl_pkg::LED_OFF;
         div1_q <= ftl_pkg::DIV_RESET;
         div2_q <= ftl_pkg::DIV_RESET;
      end else begin
         pre1_q <= pre1_d;
         pre2_q <= pre2_d;
         scan_q <= scan_d;
         mode1_q <= mode1_d;
         mode2_q <= mode2_d;
         div1_q <= div1_d;
         div2_q <= div2_d;
      end
   end

   // ************************************************************
   // Tach channels
   // ************************************************************
   ftl_pkg::ftl_tach_ctrl_type ctrl1, ctrl2;
   logic ld1, ld2;

   always_comb begin
      ld1 = wr_fire && idx == ftl_pkg::IDX_PRE_1;
      ld2 = wr_fire && idx == ftl_pkg::IDX_PRE_2;
      // New preload is taken straight from the bus on the write
      ctrl1 = '{load: ld1, div: div1_q,
                preload: ld1 ? pwdata[7:0] : pre1_q};
      ctrl2 = '{load: ld2, div: div2_q,
                preload: ld2 ? pwdata[7:0] : pre2_q};
   end

   ftl_tach #(.TICK_CYCLES(TICK_CYCLES)) u_tach_one (
      .pclk(pclk),
      .presetn(presetn),
      .ctrl(ctrl1),
      .fan_pulse(fan_channel_one),
      .result(tach1)
   );

   ftl_tach #(.TICK_CYCLES(TICK_CYCLES)) u_tach_two (
      .pclk(pclk),
      .presetn(presetn),
      .ctrl(ctrl2),
      .fan_pulse(fan_channel_two),
      .result(tach2)
   );

   // ************************************************************
   // Indicators
   // ************************************************************
   // One half-second divider serves both LEDs so they blink in step.
   logic [HW-1:0] half_q, half_d;
   logic [1:0] phase_q, phase_d;
   logic ind1_q, ind1_d, ind2_q, ind2_d;

   function automatic logic led_level(input logic [1:0] mode,
                                      input logic [1:0] ph);
      logic lit;
      lit = 1'b0;
      case (mode)
         ftl_pkg::LED_OFF: lit = 1'b0;
         ftl_pkg::LED_FAST: lit = !ph[0];
         ftl_pkg::LED_SLOW: lit = (ph == 2'h0);
         ftl_pkg::LED_ON: lit = 1'b1;
         default: lit = 1'b0;
      endcase
      return lit;
   endfunction

   always_comb begin
      half_d = (half_q == HALF_LAST) ? '0 : half_q + 1'b1;
      phase_d = (half_q == HALF_LAST) ? phase_q + 2'h1 : phase_q;
      ind1_d = led_level(mode1_q, phase_q);
      ind2_d = led_level(mode2_q, phase_q);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         half_q <= '0;
         phase_q <= 2'h0;
         ind1_q <= 1'b0;
         ind2_q <= 1'b0;
      end else begin
         half_q <= half_d;
         phase_q <= phase_d;
         ind1_q <= ind1_d;
         ind2_q <= ind2_d;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign indicator_one = ind1_q;
   assign indicator_two = ind2_q;

   // ************************************************************
   // Checks
   // ************************************************************
   chk_led_off: assert property (
      @(posedge pclk) disable iff (!presetn)
      mode1_q == ftl_pkg::LED_OFF |=> !indicator_one)
      else $error("indicator lit while off");

   chk_led_on: assert property (
      @(posedge pclk) disable iff (!presetn)
      mode2_q == ftl_pkg::LED_ON |=> indicator_two)
      else $error("indicator dark while on");

   chk_led_quarter: assert property (
      @(posedge pclk) disable iff (!presetn)
      (mode1_q == ftl_pkg::LED_SLOW && phase_q != 2'h0) |=> !indicator_one)
      else $error("slow blink lit outside its quarter");

   chk_reserved_read: assert property (
      @(posedge pclk) disable iff (!presetn)
      (rd_fire && in_range && idx >= ftl_pkg::IDX_RSV_LO &&
       idx <= ftl_pkg::IDX_RSV_HI) |-> prdata == '0)
      else $error("reserved span read non-zero");

   chk_scan_write: assert property (
      @(posedge pclk) disable iff (!presetn)
      (wr_fire && idx == ftl_pkg::IDX_SCAN)
      |=> scan_q == $past(pwdata[7:0]))
      else $error("scan code write not stored");

   chk_ready_pulse: assert property (
      @(posedge pclk) disable iff (!presetn)
      pready |=> !pready)
      else $error("pready held for two cycles");
endmodule
`default_nettype wire

//--- test_fan_tach_led_runtime_regs.sv
// Self-checking bench for the fan tach / LED / scan-code register bank.
// Assumes ftl_pkg and ftl_regs are compiled first; drives APB and fan pins.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fail_count++; \
   $display("Error at %0t: mismatch got %h exp %h", $time, (a), (b)); end end
module test_fan_tach_led_runtime_regs;
   // ************************************************************
   // Clock, reset, stimulus signals
   // ************************************************************
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] paddr = 32'h0;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'hF;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic fan_one = 1'b0;
   logic fan_two = 1'b0;
   logic indicator_one;
   logic indicator_two;
   int fail_count = 0;
   int comparisons = 0;

   initial begin
      forever #12.5 pclk = ~pclk;
   end

   // Small counts keep blink and tick periods short
   ftl_regs #(.TICK_CYCLES(2), .HALF_SEC_CYCLES(4)) dut_u (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .fan_channel_one(fan_one), .fan_channel_two(fan_two),
      .indicator_one(indicator_one), .indicator_two(indicator_two)
   );

   // ************************************************************
   // Bus and pin helpers
   // ************************************************************
   function automatic logic [31:0] ad(input logic [7:0] idx);
      return {22'h0, idx, 2'h0};
   endfunction

   task automatic apb(input logic w, input logic [31:0] a,
                      input logic [31:0] wd, output logic [31:0] rd,
                      output logic err);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      // Wait bounded; a slave that never answers is counted as a fault
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         fail_count++;
         $display("Error at %0t: no pready", $time);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [31:0] rd;
      logic err;
      apb(1'b1, ad(idx), {24'h0, d}, rd, err);
   endtask

   task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp,
                         input logic exp_err);
      logic [31:0] rd;
      logic err;
      apb(1'b0, a, 32'h0, rd, err);
      `CHK(rd, exp)
      `CHK(err, exp_err)
   endtask

   task automatic fan_hit;
      @(posedge pclk);
      fan_one <= 1'b1;
      fan_two <= 1'b1;
      @(posedge pclk);
      fan_one <= 1'b0;
      fan_two <= 1'b0;
   endtask

   // Rising edges exactly 64 cycles apart, a multiple of every tick span
   task automatic pulse_pair;
      fan_hit;
      repeat (62) @(posedge pclk);
      fan_hit;
      repeat (3) @(posedge pclk);
   endtask

   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic t_reset_values;
      rd_chk(ad(ftl_pkg::IDX_FAN_DIV), 32'h50, 1'b0);
      rd_chk(ad(ftl_pkg::IDX_TACH_1), 32'h0, 1'b0);
      rd_chk(ad(ftl_pkg::IDX_TACH_2), 32'h0, 1'b0);
      rd_chk(ad(ftl_pkg::IDX_PRE_1), 32'h0, 1'b0);
      rd_chk(ad(ftl_pkg::IDX_PRE_2), 32'h0, 1'b0);
      rd_chk(ad(ftl_pkg::IDX_LED_1), 32'h0, 1'b0);
      rd_chk(ad(ftl_pkg::IDX_LED_2), 32'h0, 1'b0);
      rd_chk(ad(ftl_pkg::IDX_SCAN), 32'h0, 1'b0);
   endtask

   task automatic t_rw_and_reserved;
      wr(ftl_pkg::IDX_SCAN, 8'hA5);
      rd_chk(ad(ftl_pkg::IDX_SCAN), 32'hA5, 1'b0);
      pstrb <= 4'hE;
      wr(ftl_pkg::IDX_SCAN, 8'h3C);
      pstrb <= 4'hF;
      rd_chk(ad(ftl_pkg::IDX_SCAN), 32'hA5, 1'b0);
      wr(ftl_pkg::IDX_PRE_2, 8'h81);
      rd_chk(ad(ftl_pkg::IDX_PRE_2), 32'h81, 1'b0);
      wr(ftl_pkg::IDX_TACH_1, 8'h77);
      rd_chk(ad(ftl_pkg::IDX_TACH_1), 32'h0, 1'b0);
      wr(ftl_pkg::IDX_RSV_LO, 8'hFF);
      rd_chk(ad(ftl_pkg::IDX_RSV_LO), 32'h0, 1'b0);
      rd_chk(ad(ftl_pkg::IDX_RSV_HI), 32'h0, 1'b0);
      rd_chk(32'h200, 32'h0, 1'b1);
      rd_chk(32'h161, 32'h0, 1'b1);
   endtask

   task automatic t_tach(input logic [7:0] div, input logic [7:0] p1,
                         input logic [7:0] p2, input logic [7:0] e1,
                         input logic [7:0] e2);
      wr(ftl_pkg::IDX_FAN_DIV, div);
      rd_chk(ad(ftl_pkg::IDX_FAN_DIV), {24'h0, div}, 1'b0);
      wr(ftl_pkg::IDX_PRE_1, p1);
      wr(ftl_pkg::IDX_PRE_2, p2);
      // First pulse after a preload write only re-aligns the count
      pulse_pair;
      rd_chk(ad(ftl_pkg::IDX_TACH_1), {24'h0, e1}, 1'b0);
      rd_chk(ad(ftl_pkg::IDX_TACH_2), {24'h0, e2}, 1'b0);
      repeat (20) @(posedge pclk);
      rd_chk(ad(ftl_pkg::IDX_TACH_1), {24'h0, e1}, 1'b0);
   endtask

   task automatic t_preload_restart;
      logic [31:0] rd;
      logic err;
      wr(ftl_pkg::IDX_FAN_DIV, 8'h00);
      wr(ftl_pkg::IDX_PRE_1, 8'h00);
      fan_hit;
      repeat (40) @(posedge pclk);
      wr(ftl_pkg::IDX_PRE_1, 8'h80);
      repeat (4) @(posedge pclk);
      fan_hit;
      repeat (3) @(posedge pclk);
      apb(1'b0, ad(ftl_pkg::IDX_TACH_1), 32'h0, rd, err);
      `CHK(rd[7:4], 4'h8)
   endtask

   task automatic led_count(input logic [7:0] c1, input logic [7:0] c2,
                            input int e1, input int e2);
      int n1;
      int n2;
      n1 = 0;
      n2 = 0;
      wr(ftl_pkg::IDX_LED_1, c1);
      wr(ftl_pkg::IDX_LED_2, c2);
      repeat (3) @(posedge pclk);
      // One full slow period in any alignment
      repeat (16) begin
         @(posedge pclk);
         n1 += (indicator_one === 1'b1);
         n2 += (indicator_two === 1'b1);
      end
      `CHK(n1, e1)
      `CHK(n2, e2)
   endtask

   task automatic t_leds;
      led_count(8'hFD, 8'h02, 8, 4);
      rd_chk(ad(ftl_pkg::IDX_LED_1), 32'h1, 1'b0);
      led_count(8'h03, 8'hFC, 16, 0);
      led_count(8'h06, 8'hFF, 4, 16);
   endtask

   task automatic t_second_reset;
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      t_reset_values;
   endtask

   task automatic end_sim;
      $display("comparisons %0d fail_count %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // ************************************************************
   // Main sequence and watchdog
   // ************************************************************
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      t_reset_values;
      t_rw_and_reserved;
      t_tach(8'h80, 8'h10, 8'h20, 8'h30, 8'h28);
      t_tach(8'h70, 8'h10, 8'h20, 8'h14, 8'h30);
      t_tach(8'h00, 8'hF0, 8'h20, 8'hFF, 8'h40);
      t_preload_restart;
      t_leds;
      t_second_reset;
      end_sim;
   end

   initial begin
      repeat (20000) @(posedge pclk);
      fail_count++;
      $display("Error at %0t: watchdog expired", $time);
      end_sim;
   end
endmodule
`default_nettype wire
